// ---- logic/adc_serial_port.sv ----
// Notes on behaviour
// - Power down at busy fall if start still low, up on start rise.
// - Five-wire: result out, control byte in separately.
// - Slave only; host supplies every serial clock.
// - Direction low writes, high reads.
// - Five-wire read: select low, direction rise drives top.
// - Later bits on falling clock, first fall skipped.
// - Up to ten bits, top first.
// - Output released on direction fall, or on select rise in five-wire form.
// - Reading erases result until next conversion.
// - First eight rising clocks captured, rest ignored.
// - Three-wire: direction high makes pin output, top bit.
// - Three-wire shifts from second falling clock edge.
// - Three-wire pin returns input on direction fall.
// - Channel field zero selects temperature, reset default.
`timescale 1ns/1ps
`default_nettype none

module adc_serial_port
    import adc_port_pkg::*;
(
    input  wire logic                     ref_clk_in,
    input  wire logic                     rst_n_in,
    input  wire logic                     sclk_in,
    input  wire logic                     dir_in,
    input  wire logic                     sel_n_in,
    input  wire logic                     data_in,
    input  wire logic                     conversion_start_n_in,
    input  wire logic                     three_wire_in,
    input  wire logic                     busy_in,
    input  wire logic [`ADC_RESULT_W-1:0] result_in,
    output logic                          data_out,
    output logic                          data_oe_out,
    output var ctrl_byte_t                control_out,
    output logic                          result_valid_out,
    output logic                          power_down_out
);

    ////////////////////////////////////////////////////////////////////////////
    // Pin capture and edge detection

    pins_t                    raw;
    pins_t                    s;
    pins_t                    prev;
    pins_t                    rise;
    pins_t                    fall;
    logic [1:0]               settle;
    logic                     busy_prev;
    logic                     busy_fall;
    logic                     sel_ok;
    logic                     start_read;
    logic                     stop_read;
    logic                     shift_ev;
    link_state_t              state;
    logic [`ADC_RESULT_W-1:0] result;
    logic [`ADC_RESULT_W-1:0] shift;
    logic                     fall_seen;
    logic [3:0]               rd_shifts;
    logic [3:0]               wr_cnt;
    logic [`ADC_CTRL_W-1:0]   wr_shift;

    assign raw = '{sclk: sclk_in, dir: dir_in, sel_n: sel_n_in, data: data_in,
                   start_n: conversion_start_n_in, three_wire: three_wire_in};

    pin_sync #(
        .WIDTH(`ADC_PIN_W)
    ) u_sync (
        .ref_clk_in(ref_clk_in),
        .rst_n_in  (rst_n_in),
        .async_in  (raw),
        .sync_out  (s)
    );

    // Edges masked until the synchroniser has filled, so pins held at reset
    // do not look like fresh edges
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            prev   <= '0;
            settle <= '0;
        end else begin
            prev <= s;
            if (settle != `ADC_SETTLE_MAX) begin
                settle <= settle + `ADC_SETTLE_ONE;
            end
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            busy_prev <= 1'b0;
        end else begin
            busy_prev <= busy_in;
        end
    end

    assign rise      = (settle == `ADC_SETTLE_MAX) ? pins_t'(s & ~prev) : '0;
    assign fall      = (settle == `ADC_SETTLE_MAX) ? pins_t'(~s & prev) : '0;
    assign busy_fall = busy_prev & ~busy_in;
    // Three-wire form has no select; it behaves as if tied low
    assign sel_ok     = s.three_wire | ~s.sel_n;
    assign start_read = rise.dir & sel_ok;
    assign stop_read  = fall.dir | (~s.three_wire & rise.sel_n);
    assign shift_ev   = (state == LINK_READ) & fall.sclk & fall_seen &
                        (rd_shifts != `ADC_RD_SHIFTS) & ~stop_read & ~start_read;

    ////////////////////////////////////////////////////////////////////////////
    // Link state

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state <= LINK_IDLE;
        end else begin
            case (state)
                LINK_IDLE,
                LINK_READ,
                LINK_WRITE: begin
                    if (fall.dir) begin
                        state <= LINK_WRITE;
                    end else if (start_read) begin
                        state <= LINK_READ;
                    end else if (rise.dir || (state == LINK_READ && stop_read)) begin
                        state <= LINK_IDLE;
                    end
                end
                default: begin
                    state <= LINK_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Result store

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            result           <= '0;
            result_valid_out <= 1'b0;
        end else begin
            if (busy_fall) begin
                result           <= result_in;
                result_valid_out <= 1'b1;
            end else if (start_read) begin
                result_valid_out <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read shifter

    // host clocks only
    // Shifting follows host edges alone; nothing here makes a clock
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            shift       <= '0;
            fall_seen   <= 1'b0;
            rd_shifts   <= `ADC_CNT_ZERO;
            data_out    <= 1'b0;
            data_oe_out <= 1'b0;
        end else begin
            if (stop_read) begin
                data_oe_out <= 1'b0;
            end else if (start_read) begin
                data_oe_out <= 1'b1;
                fall_seen   <= 1'b0;
                rd_shifts   <= `ADC_CNT_ZERO;
                // Erased result reads back as zeros
                shift       <= result_valid_out ? result : '0;
                data_out    <= result_valid_out & result[`ADC_RESULT_W-1];
            end else if (state == LINK_READ && fall.sclk && !fall_seen) begin
                fall_seen <= 1'b1;
            end else if (shift_ev) begin
                shift     <= {shift[`ADC_RESULT_W-2:0], 1'b0};
                data_out  <= shift[`ADC_RESULT_W-2];
                rd_shifts <= rd_shifts + `ADC_CNT_ONE;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control byte write

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wr_cnt      <= `ADC_CNT_ZERO;
            wr_shift    <= '0;
            control_out <= ctrl_byte_t'(`ADC_CTRL_RESET);
        end else begin
            if (fall.dir) begin
                wr_cnt <= `ADC_CNT_ZERO;
            end else if (state == LINK_WRITE && sel_ok && rise.sclk &&
                         wr_cnt != `ADC_WR_FULL) begin
                wr_shift <= {wr_shift[`ADC_CTRL_W-2:0], s.data};
                wr_cnt   <= wr_cnt + `ADC_CNT_ONE;
                if (wr_cnt == `ADC_WR_LAST) begin
                    control_out <= ctrl_byte_t'({wr_shift[`ADC_CTRL_W-2:0], s.data});
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Automatic power-down

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            power_down_out <= 1'b0;
        end else begin
            if (busy_fall && !s.start_n) begin
                power_down_out <= 1'b1;
            end else if (rise.start_n) begin
                power_down_out <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!rst_n_in);

    a_pd_busy_fall: assert property (busy_fall && !s.start_n && !rise.start_n |=> power_down_out)
        else $error("no power-down at conversion end");
    a_pu_start_rise: assert property (rise.start_n |=> !power_down_out ##1 !power_down_out or busy_fall)
        else $error("no power-up on start rise");
    a_release_dir: assert property (fall.dir |=> !data_oe_out)
        else $error("pin still driven after direction fall");
    a_release_sel: assert property (!s.three_wire && rise.sel_n |=> !data_oe_out)
        else $error("output still driven after select rise");
    a_top_bit: assert property (start_read && !stop_read && result_valid_out && !busy_fall
                                |=> data_oe_out && data_out == $past(result[`ADC_RESULT_W-1]))
        else $error("top bit not presented on direction rise");
    a_result_erased: assert property (start_read && !busy_fall |=> !result_valid_out)
        else $error("result still valid after read");
    a_shift_fall: assert property (shift_ev |=> data_out == $past(shift[`ADC_RESULT_W-2]))
        else $error("wrong bit after falling clock");
    a_bit_limit: assert property (rd_shifts <= `ADC_RD_SHIFTS)
        else $error("more than ten bits shifted");
    a_write_cap: assert property (wr_cnt == `ADC_WR_FULL && !fall.dir |=> wr_cnt == `ADC_WR_FULL)
        else $error("write counted past eight bits");
    a_ctrl_hold: assert property (wr_cnt < `ADC_WR_LAST || state != LINK_WRITE
                                  |=> $stable(control_out))
        else $error("control changed before eight bits");
    a_out_source: assert property ($changed(data_out) |-> $past(start_read || shift_ev))
        else $error("output changed without host edge");

    c_read_start: cover property (start_read && result_valid_out);
    c_full_read:  cover property (rd_shifts == `ADC_RD_SHIFTS);
    c_write_done: cover property (wr_cnt == `ADC_WR_LAST && rise.sclk && state == LINK_WRITE);
    c_power_down: cover property (busy_fall && !s.start_n);

endmodule

`default_nettype wire

// ---- logic/adc_port_defs.svh ----
`ifndef ADC_PORT_DEFS_SVH
`define ADC_PORT_DEFS_SVH

`define ADC_RESULT_W   10
`define ADC_CTRL_W     8
`define ADC_PIN_W      6
`define ADC_CTRL_RESET 8'h00
`define ADC_RD_SHIFTS  4'h9
`define ADC_WR_LAST    4'h7
`define ADC_WR_FULL    4'h8
`define ADC_CNT_ZERO   4'h0
`define ADC_CNT_ONE    4'h1
`define ADC_SETTLE_MAX 2'h3
`define ADC_SETTLE_ONE 2'h1
`define ADC_CHAN_TEMP  3'h0

`endif

// ---- logic/adc_port_pkg.sv ----
`include "adc_port_defs.svh"

package adc_port_pkg;

    // Synchronised pin bundle, one bit per pin
    typedef struct packed {
        logic sclk;
        logic dir;
        logic sel_n;
        logic data;
        logic start_n;
        logic three_wire;
    } pins_t;

    // Control byte as shifted in, first bit in the top position
    typedef struct packed {
        logic [2:0] channel;
        logic [4:0] options;
    } ctrl_byte_t;

    typedef enum logic [1:0] {
        LINK_IDLE,
        LINK_READ,
        LINK_WRITE
    } link_state_t;

endpackage

// ---- logic/pin_sync.sv ----
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
    parameter int WIDTH = 6
) (
    input  wire logic             ref_clk_in,
    input  wire logic             rst_n_in,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
                if (!rst_n_in) begin
                    stage1[i]   <= 1'b0;
                    sync_out[i] <= 1'b0;
                end else begin
                    stage1[i]   <= async_in[i];
                    sync_out[i] <= stage1[i];
                end
            end
        end
    endgenerate

endmodule

`default_nettype wire

// ---- testbench/host_link.sv ----
`timescale 1ns/1ps
`default_nettype none

module host_link (
    input  wire logic ref_clk_in,
    input  wire logic line_in,
    output logic      sclk_out,
    output logic      dir_out,
    output logic      sel_n_out,
    output logic      data_out,
    output logic      data_oe_out,
    output logic      conversion_start_n_out
);
    // Clock, direction and start idle high, select and data low, so pins held at release give no edge
    initial begin
        sclk_out = 1'b1;
        dir_out = 1'b1;
        sel_n_out = 1'b0;
        data_out = 1'b0;
        data_oe_out = 1'b0;
        conversion_start_n_out = 1'b1;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_in);
    endtask

    task automatic read_start();
        dir_out <= 1'b0;
        tick(8);
        dir_out <= 1'b1;
        tick(8);
    endtask

    task automatic read_bits(input int n, output logic [9:0] got);
        got = 10'h000;
        for (int i = 0; i < n; i++) begin
            sclk_out <= 1'b0;
            tick(6);
            got = {got[8:0], line_in};
            sclk_out <= 1'b1;
            // Periods of 12 and 13 cycles in turn average 125 ns
            tick(6 + (i % 2));
        end
    endtask

    task automatic read_end();
        dir_out <= 1'b0;
        tick(8);
    endtask

    // high then low before each write
    task automatic write(input logic [9:0] bits, input int n);
        dir_out <= 1'b1;
        tick(8);
        dir_out <= 1'b0;
        tick(8);
        for (int i = 9; i > 9 - n; i--) begin
            sclk_out <= 1'b0;
            data_out <= bits[i];
            data_oe_out <= 1'b1;
            tick(6);
            sclk_out <= 1'b1;
            tick(6 + (i % 2));
        end
        data_oe_out <= 1'b0;
        tick(4);
    endtask

    task automatic set_sel(input logic v);
        sel_n_out <= v;
        tick(4);
    endtask

    task automatic set_start(input logic v);
        conversion_start_n_out <= v;
    endtask
endmodule

`default_nettype wire

// ---- testbench/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import adc_port_pkg::*;
    logic       ref_clk_in = 1'b0;
    // 2 us power-up time at 100 MHz
    localparam int POWER_UP_CYCLES = 200;
    logic       rst_n_in;
    logic       three_wire;
    logic       busy;
    logic       float_bit = 1'b0;
    logic [9:0] result;
    logic [9:0] g;
    logic [9:0] g2;
    logic       dout, oe, valid, pd;
    ctrl_byte_t control;
    wire logic  sclk, dir, sel_n, host_data, host_oe, conv_n, line, din;
    int         fail_count = 0;
    int         samples_checked = 0;

    always #5 ref_clk_in = ~ref_clk_in;
    // Undriven line wanders so stale bits cannot pass
    always_ff @(posedge ref_clk_in) float_bit <= ~float_bit;
    assign line = oe ? dout : (host_oe ? host_data : float_bit);
    // Five-wire form keeps the input line apart from the output line
    assign din = three_wire ? line : host_data;

    adc_serial_port DUT (
        .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .sclk_in(sclk), .dir_in(dir),
        .sel_n_in(sel_n), .data_in(din), .conversion_start_n_in(conv_n),
        .three_wire_in(three_wire), .busy_in(busy), .result_in(result),
        .data_out(dout), .data_oe_out(oe), .control_out(control),
        .result_valid_out(valid), .power_down_out(pd)
    );

    host_link host (
        .ref_clk_in(ref_clk_in), .line_in(line), .sclk_out(sclk), .dir_out(dir),
        .sel_n_out(sel_n), .data_out(host_data), .data_oe_out(host_oe),
        .conversion_start_n_out(conv_n)
    );

    ////////////////////////////////////////////////////////////////////////////
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_in);
    endtask

    task automatic chk(input string what, input logic [9:0] exp, input logic [9:0] got);
        samples_checked++;
        if (got !== exp) begin
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
            fail_count++;
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // start held for the 2 us power-up time
    task automatic convert(input logic [9:0] v, input logic mode2);
        host.set_start(1'b0);
        busy <= 1'b1;
        result <= v;
        tick(POWER_UP_CYCLES);
        if (!mode2) host.set_start(1'b1);
        tick(10);
        busy <= 1'b0;
        tick(3);
        chk("result valid", 10'h001, {9'h0, valid});
        chk("power down", {9'h0, mode2}, {9'h0, pd});
        if (mode2) begin
            tick(170);
            host.set_start(1'b1);
            tick(5);
            chk("power up", 10'h000, {9'h0, pd});
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        chk("control", 10'h000, {2'b00, control});
        chk("idle outputs", 10'h000, {7'h0, oe, valid, pd});
    endtask

    task automatic t_five_read();
        convert(10'h2d6, 1'b0);
        host.read_start();
        chk("enable", 10'h001, {9'h0, oe});
        chk("erased", 10'h000, {9'h0, valid});
        host.read_bits(8, g);
        tick(30);
        host.read_bits(2, g2);
        chk("read", 10'h2d6, {g[7:0], g2[1:0]});
        host.read_end();
        chk("released", 10'h000, {9'h0, oe});
        host.read_start();
        host.read_bits(10, g);
        chk("reread", 10'h000, g);
        host.read_end();
    endtask

    task automatic t_select();
        convert(10'h3c5, 1'b0);
        host.set_sel(1'b1);
        host.read_start();
        chk("unselected", 10'h003, {8'h0, ~oe, valid});
        host.read_end();
        host.set_sel(1'b0);
        host.read_start();
        host.read_bits(8, g);
        chk("top byte", 10'h0f1, g);
        host.set_sel(1'b1);
        chk("select release", 10'h000, {9'h0, oe});
        host.set_sel(1'b0);
        host.read_end();
    endtask

    task automatic t_write();
        host.write({8'ha5, 2'b11}, 10);
        chk("control", 10'h0a5, {2'b00, control});
        host.write({8'h1f, 2'b00}, 8);
        chk("channel", 10'h000, {7'h0, control.channel});
        host.write({8'hff, 2'b00}, 5);
        host.read_start();
        host.read_end();
        chk("aborted", 10'h01f, {2'b00, control});
    endtask

    task automatic t_three_wire();
        three_wire <= 1'b1;
        host.set_sel(1'b1);
        convert(10'h15a, 1'b0);
        host.read_start();
        chk("pin output", 10'h001, {9'h0, oe});
        host.read_bits(10, g);
        chk("read", 10'h15a, g);
        host.read_end();
        chk("pin input", 10'h000, {9'h0, oe});
        host.write({8'h62, 2'b00}, 8);
        chk("control", 10'h062, {2'b00, control});
        three_wire <= 1'b0;
        host.set_sel(1'b0);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        rst_n_in <= 1'b0;
        three_wire <= 1'b0;
        busy <= 1'b0;
        result <= 10'h000;
        tick(4);
        rst_n_in <= 1'b1;
        tick(6);
        t_reset();
        t_five_read();
        t_select();
        t_write();
        t_three_wire();
        convert(10'h200, 1'b1);
        wrap_up();
    end

    initial begin
        tick(60000);
        fail_count++;
        wrap_up();
    end
endmodule

`default_nettype wire
